/* File: npt_indirect_regs.sv */
// Indirect byte access to the per-port next page transmit words
module npt_indirect_regs
#(
  parameter int NPORTS = 2  // Ports carrying the register, from port 3 up
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire npt_pkg::npt_bus_req_type bus_i,
  input wire npt_pkg::npt_link_ev_type [NPORTS-1:0] link_i,
  input wire logic [NPORTS-1:0] auto_eee_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic [NPORTS-1:0][15:0] tx_word_o,
  output logic [NPORTS-1:0] manual_np_o
);
  import npt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  // Selection, read port and mode flags; all load constants in reset
  logic [7:0] ctrl;          // Function and port select
  logic [7:0] next_ctrl;
  logic [7:0] offs;          // Indirect byte offset
  logic [7:0] next_offs;
  logic [7:0] rdata;         // Read data register
  logic [7:0] next_rdata;
  logic rvalid;              // Read answer strobe
  logic next_rvalid;
  logic [NPORTS-1:0] manual; // Software-programmed pages in use
  logic [NPORTS-1:0] next_manual;

  logic [NPORTS-1:0][15:0] words; // Per-port stored words
  logic [NPORTS-1:0] hit_hi;      // Window aims at upper byte of port
  logic [NPORTS-1:0] hit_lo;      // Window aims at lower byte of port
  logic eee_space;                // EEE function selected
  logic win_acc;                  // Request addresses the window

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the indirect selection, shared by reads and writes
  // The selection sits in flops, so the window decode is steady within a cycle
  assign eee_space = ctrl[NPT_FUNC_MSB:NPT_FUNC_LSB] == NPT_FUNC_EEE;
  // Only the data window reaches the words; control and offset never do
  assign win_acc = bus_i.addr == NPT_DATA_ADDR;

  ////////////////////////////////////////////////////////////////////////////
  // Per-port word storage
  generate
    for (genvar g = 0; g < NPORTS; g++)
    begin : g_port
      localparam logic [3:0] PORT_ID = NPT_PORT_FIRST + 4'(g);
      logic port_sel; // This port picked in control

      assign port_sel = eee_space && ctrl[NPT_PORT_MSB:NPT_PORT_LSB] == PORT_ID;
      assign hit_hi[g] = port_sel && offs == NPT_OFS_HI;
      assign hit_lo[g] = port_sel && offs == NPT_OFS_LO;

      // Slot g holds device port 3 + g
      npt_port_word u_word
      (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_hi_i(bus_i.wr && win_acc && hit_hi[g]),
        .wr_lo_i(bus_i.wr && win_acc && hit_lo[g]),
        .wdata_i(bus_i.data),
        .ev_i(link_i[g]),
        .word_o(words[g])
      );

      // Each port answers at its own two offsets only
      a_port_hi_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        bus_i.rd && win_acc && hit_hi[g] |=> rdata_o == words[g][15:8])
        else $error("Port upper byte read wrong");
      a_port_lo_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        bus_i.rd && win_acc && hit_lo[g] |=> rdata_o == words[g][7:0])
        else $error("Port lower byte read wrong");
      // Software bits move only on a window write aimed at this port; the toggle belongs to the link
      a_port_write_guard: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(bus_i.wr && win_acc && (hit_hi[g] || hit_lo[g]))
        |=> (words[g] & NPT_WR_MASK) == ($past(words[g]) & NPT_WR_MASK))
        else $error("Word changed without a window write");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next values of control, offset, read data and mode flags
  // Read data comes from the current words, so a read right after a write sees it
  always_comb
  begin
    next_ctrl = ctrl;
    next_offs = offs;
    next_rdata = rdata;
    next_rvalid = bus_i.rd;
    // Automatic exchange leaves the programmed page unused
    next_manual = ~auto_eee_i;
    // Control byte: function in 7:5, port in 3:0; bit 4 is kept but has no effect
    if (bus_i.wr && bus_i.addr == NPT_CTRL_ADDR)
    begin
      next_ctrl = bus_i.data;
    end
    // Offset byte picks which half of the word the window shows
    if (bus_i.wr && bus_i.addr == NPT_OFFS_ADDR)
    begin
      next_offs = bus_i.data;
    end
    if (bus_i.rd)
    begin
      // Unknown address or selection answers zero
      next_rdata = 8'h00;
      // Selection registers read back as written
      if (bus_i.addr == NPT_CTRL_ADDR)
      begin
        next_rdata = ctrl;
      end
      else if (bus_i.addr == NPT_OFFS_ADDR)
      begin
        next_rdata = offs;
      end
      // Window: the hit port's byte; ports never overlap, so at most one hit is set
      else if (win_acc)
      begin
        // Walk all ports rather than index by port number, which may be out of range
        for (int i = 0; i < NPORTS; i++)
        begin
          if (hit_hi[i])
          begin
            next_rdata = words[i][15:8];
          end
          if (hit_lo[i])
          begin
            next_rdata = words[i][7:0];
          end
        end
      end
    end
  end

  // Register only; reset is synchronous and loads constants, every other cycle loads the next values
  // A cleared selection points at no port, so a stray window access after reset is harmless
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl <= NPT_CTRL_RESET;
      offs <= NPT_OFFS_RESET;
      rdata <= 8'h00;
      rvalid <= 1'b0;
      manual <= '0;
    end
    else
    begin
      ctrl <= next_ctrl;
      offs <= next_offs;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      manual <= next_manual;
    end
  end

  // Outputs straight from flops
  // The words come from the per-port flops, so no extra stage is needed
  assign rdata_o = rdata;
  assign rvalid_o = rvalid;
  assign tx_word_o = words;
  assign manual_np_o = manual;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_hi_byte_read: assert property (bus_i.rd && win_acc && hit_hi[0] |=> rdata_o == words[0][15:8])
    else $error("Upper byte not at offset 0x0E");
  a_lo_byte_read: assert property (bus_i.rd && win_acc && hit_lo[0] |=> rdata_o == words[0][7:0])
    else $error("Lower byte not at offset 0x0F");
  a_window_other: assert property (bus_i.rd && win_acc && !(|hit_hi) && !(|hit_lo) |=> rdata_o == 8'h00)
    else $error("Unselected window read not zero");
  a_read_answer: assert property (bus_i.rd |=> rvalid_o ##1 (rvalid_o == $past(bus_i.rd)))
    else $error("Read answer strobe wrong");
  a_auto_mode: assert property (##1 manual_np_o == ~$past(auto_eee_i))
    else $error("Manual page flag wrong");
  a_write_sticks: assert property (bus_i.wr && win_acc && hit_lo[0]
    ##1 bus_i.rd && win_acc && hit_lo[0] |=> rdata_o == $past(bus_i.data, 2))
    else $error("Window write not read back");

  // Selection registers take the written byte whole
  a_ctrl_write: assert property (bus_i.wr && bus_i.addr == NPT_CTRL_ADDR |=> ctrl == $past(bus_i.data))
    else $error("Control write lost");
  a_offs_write: assert property (bus_i.wr && bus_i.addr == NPT_OFFS_ADDR |=> offs == $past(bus_i.data))
    else $error("Offset write lost");
  a_ctrl_read: assert property (bus_i.rd && bus_i.addr == NPT_CTRL_ADDR |=> rdata_o == $past(ctrl))
    else $error("Control read back wrong");
  a_offs_read: assert property (bus_i.rd && bus_i.addr == NPT_OFFS_ADDR |=> rdata_o == $past(offs))
    else $error("Offset read back wrong");

  // Read data holds between reads, so a slow reader still finds it
  a_read_quiet: assert property (!bus_i.rd |=> !rvalid_o && $stable(rdata_o))
    else $error("Read answer moved without a read");
  // Any address outside the three byte registers answers zero and changes nothing
  a_unmapped_read: assert property (bus_i.rd && !win_acc
    && bus_i.addr != NPT_CTRL_ADDR && bus_i.addr != NPT_OFFS_ADDR |=> rdata_o == 8'h00)
    else $error("Unmapped read not zero");
  a_unmapped_write: assert property (bus_i.wr && bus_i.addr != NPT_CTRL_ADDR
    && bus_i.addr != NPT_OFFS_ADDR |=> $stable(ctrl) && $stable(offs))
    else $error("Unmapped write changed selection");

  // Each selection field on its own must be able to refuse the window
  a_space_gate: assert property (bus_i.rd && win_acc && !eee_space |=> rdata_o == 8'h00)
    else $error("Window answered outside the EEE space");
  a_port_gate: assert property (bus_i.rd && win_acc
    && (ctrl[NPT_PORT_MSB:NPT_PORT_LSB] < NPT_PORT_FIRST
    || ctrl[NPT_PORT_MSB:NPT_PORT_LSB] >= NPT_PORT_FIRST + NPORTS) |=> rdata_o == 8'h00)
    else $error("Window answered for a port without the word");
  a_offs_gate: assert property (bus_i.rd && win_acc
    && offs != NPT_OFS_HI && offs != NPT_OFS_LO |=> rdata_o == 8'h00)
    else $error("Window answered at a foreign offset");

  c_hi_read: cover property (bus_i.rd && win_acc && hit_hi[0]);
  c_lo_write: cover property (bus_i.wr && win_acc && hit_lo[NPORTS-1]);
  c_auto_off: cover property (manual_np_o[0]);
  c_refused_read: cover property (bus_i.rd && win_acc && !(|hit_hi) && !(|hit_lo));
endmodule

/* File: npt_pkg.sv */
// Constants and carrier types for the next page transmit register block
package npt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Byte register addresses on the management port
  localparam logic [7:0] NPT_CTRL_ADDR = 8'h6E;  // Function and port select
  localparam logic [7:0] NPT_OFFS_ADDR = 8'h6F;  // Indirect byte offset
  localparam logic [7:0] NPT_DATA_ADDR = 8'hA0;  // Indirect byte data window

  // Control register fields
  localparam int NPT_FUNC_MSB = 7;
  localparam int NPT_FUNC_LSB = 5;
  localparam int NPT_PORT_MSB = 3;
  localparam int NPT_PORT_LSB = 0;
  localparam logic [2:0] NPT_FUNC_EEE = 3'h1;     // EEE register space
  localparam logic [3:0] NPT_PORT_FIRST = 4'h3;   // Lowest port with this register
  localparam logic [7:0] NPT_CTRL_RESET = 8'h00;
  localparam logic [7:0] NPT_OFFS_RESET = 8'h00;

  // Indirect offsets of the two bytes
  localparam logic [7:0] NPT_OFS_HI = 8'h0E;      // Bits 15:8
  localparam logic [7:0] NPT_OFS_LO = 8'h0F;      // Bits 7:0

  ////////////////////////////////////////////////////////////////////////////
  // Next page word fields
  localparam int NPT_MORE_BIT = 15;
  localparam int NPT_RSVD_BIT = 14;
  localparam int NPT_MSG_BIT = 13;
  localparam int NPT_COMPLY_BIT = 12;
  localparam int NPT_TOGGLE_BIT = 11;
  localparam int NPT_CODE_MSB = 10;
  localparam logic [15:0] NPT_WORD_RESET = 16'h2001;  // Message page, code 1
  localparam logic [15:0] NPT_WR_MASK = 16'hB7FF;     // Software-writable bits

  ////////////////////////////////////////////////////////////////////////////
  // Management byte access, one cycle per request
  typedef struct packed
  {
    logic wr;         // Write strobe
    logic rd;         // Read strobe
    logic [7:0] addr; // Byte register address
    logic [7:0] data; // Write data
  } npt_bus_req_type;

  // Link-side events from the auto-negotiation arbiter, per port
  typedef struct packed
  {
    logic start;       // Next page exchange begins
    logic page_done;   // One link codeword exchanged
    logic base_toggle; // Bit 11 of the base link codeword
  } npt_link_ev_type;

endpackage

/* File: npt_port_word.sv */
// One port's next page transmit word with its toggle logic
module npt_port_word
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_hi_i,
  input wire logic wr_lo_i,
  input wire logic [7:0] wdata_i,
  input wire npt_pkg::npt_link_ev_type ev_i,
  output logic [15:0] word_o
);
  import npt_pkg::*;

  logic [15:0] word;       // Stored word
  logic [15:0] next_word;  // Next value of the word

  ////////////////////////////////////////////////////////////////////////////
  // Next word: byte writes under mask, toggle driven by the link only
  always_comb
  begin
    next_word = word;
    // Masked writes keep the toggle and reserved bit out of software reach
    if (wr_hi_i)
    begin
      next_word[15:8] = (wdata_i & NPT_WR_MASK[15:8]) | (word[15:8] & ~NPT_WR_MASK[15:8]);
    end
    if (wr_lo_i)
    begin
      next_word[7:0] = wdata_i;
    end
    // Start of exchange seeds toggle from the base page
    if (ev_i.start)
    begin
      next_word[NPT_TOGGLE_BIT] = ~ev_i.base_toggle;
    end
    else if (ev_i.page_done)
    begin
      next_word[NPT_TOGGLE_BIT] = ~word[NPT_TOGGLE_BIT];
    end
    next_word[NPT_RSVD_BIT] = 1'b0;
  end

  // Register only
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      word <= NPT_WORD_RESET;
    end
    else
    begin
      word <= next_word;
    end
  end

  assign word_o = word;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_rsvd_reads_zero: assert property (word[NPT_RSVD_BIT] == 1'b0)
    else $error("Reserved bit set");
  a_toggle_seeded: assert property (ev_i.start |=> word[NPT_TOGGLE_BIT] == !$past(ev_i.base_toggle))
    else $error("Toggle not seeded from base page");
  a_toggle_flips: assert property (!ev_i.start && ev_i.page_done
    |=> word[NPT_TOGGLE_BIT] != $past(word[NPT_TOGGLE_BIT]))
    else $error("Toggle did not flip");
  a_toggle_holds: assert property (!ev_i.start && !ev_i.page_done |=> $stable(word[NPT_TOGGLE_BIT]))
    else $error("Toggle moved without link event");
  a_hi_write_stores: assert property (wr_hi_i
    |=> word[15] == $past(wdata_i[7]) && word[13:12] == $past(wdata_i[5:4]) && word[10:8] == $past(wdata_i[2:0]))
    else $error("Upper byte write lost");
  a_lo_write_stores: assert property (wr_lo_i |=> word[7:0] == $past(wdata_i))
    else $error("Lower byte write lost");
  c_toggle_flip: cover property (ev_i.page_done ##1 ev_i.page_done);
endmodule

/* File: npt_sw_model.sv */
// Software-side model issuing indirect byte accesses on the management bus
module npt_sw_model
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output npt_pkg::npt_bus_req_type bus_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import npt_pkg::*;
  initial bus_o = '0;
  ////////////////////////////////////////////////////////////////////////////
  // One strobe cycle; idle fields inverted so stale values never look valid
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_i);
    bus_o = '{wr: w, rd: !w, addr: a, data: d};
    @(negedge clk_i);
    bus_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    // Missing answer pulse gives unknown data, so the compare fails
    q = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
  endtask
  // Write then read in the very next cycle, so the new byte must be readable at once
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_i);
    bus_o = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(negedge clk_i);
    bus_o = '{wr: 1'b0, rd: 1'b1, addr: a, data: ~d};
    @(negedge clk_i);
    bus_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    q = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
  endtask
  // Space, port and offset selection ahead of a window access
  task automatic sel(input logic [2:0] f, input logic [3:0] p, input logic [7:0] o);
    logic [7:0] q;
    acc(1'b1, NPT_CTRL_ADDR, {f, 1'b0, p}, q);
    acc(1'b1, NPT_OFFS_ADDR, o, q);
  endtask
endmodule

/* File: tb_autoneg_next_page_tx_register.sv */
// Self-checking bench for the indirect next page transmit words
module tb_autoneg_next_page_tx_register;
  timeunit 1ns;
  timeprecision 100ps;
  import npt_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  npt_bus_req_type bus; // Driven by the software model
  npt_link_ev_type [1:0] link = '0; // Arbiter events per port
  logic [1:0] auto_eee = 2'b11; // Automatic exchange on at reset
  logic [7:0] rdata;
  logic rvalid;
  logic [1:0][15:0] tx_word;
  logic [1:0] manual_np;
  logic [15:0] exp_w [2]; // Expected word per port
  int error_cnt = 0;
  int tests_run = 0;
  always #2.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  npt_sw_model npt_sw_model_i (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .bus_o(bus));
  npt_indirect_regs #(.NPORTS(2)) npt_indirect_regs_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus),
    .link_i(link), .auto_eee_i(auto_eee), .rdata_o(rdata), .rvalid_o(rvalid), .tx_word_o(tx_word),
    .manual_np_o(manual_np));
  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks, one per result width
  task automatic cmp_b(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmp_w(input string n, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Byte write merge: toggle bit keeps its old value, reserved bit is cleared
  function automatic logic [15:0] upd(input logic [15:0] w, input logic hi, input logic [7:0] d);
    logic [15:0] m;
    m = hi ? {d, w[7:0]} : {w[15:8], d};
    return (m & 16'hb7ff) | (w & 16'h0800);
  endfunction
  task automatic wbyte(input int g, input logic hi, input logic [7:0] d);
    logic [7:0] q;
    npt_sw_model_i.sel(3'h1, 4'(g + 3), hi ? 8'h0e : 8'h0f);
    npt_sw_model_i.acc(1'b1, 8'ha0, d, q);
  endtask
  // Both bytes back through the window, plus the outgoing word
  task automatic chk(input int g);
    logic [7:0] q;
    npt_sw_model_i.sel(3'h1, 4'(g + 3), 8'h0e);
    npt_sw_model_i.acc(1'b0, 8'ha0, 8'h00, q);
    cmp_b("hi byte", exp_w[g][15:8], q);
    npt_sw_model_i.sel(3'h1, 4'(g + 3), 8'h0f);
    npt_sw_model_i.acc(1'b0, 8'ha0, 8'h00, q);
    cmp_b("lo byte", exp_w[g][7:0], q);
    cmp_w("tx word", exp_w[g], tx_word[g]);
  endtask
  // One arbiter pulse: start or page done
  task automatic ev(input int g, input logic st, input logic bt);
    @(negedge clk_i);
    link[g] = '{start: st, page_done: !st, base_toggle: bt};
    @(negedge clk_i);
    link[g] = '0;
    exp_w[g][11] = st ? !bt : !exp_w[g][11];
    cmp_w("toggle word", exp_w[g], tx_word[g]);
  endtask
  task automatic close_out();
    $display("Checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    int unsigned s;
    int g;
    logic hi;
    logic [7:0] d;
    logic [7:0] q;
    logic [14:0] bad [3];
    s = $urandom(32'hdc9f);
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    cmp_b("manual flag", 8'h00, {6'h00, manual_np});
    for (g = 0; g < 2; g++)
    begin
      exp_w[g] = 16'h2001;
      chk(g);
      ev(g, 1'b1, g[0]);
    end
    // First two passes are an all-ones upper byte corner, then random traffic with link events
    for (int i = 0; i < 24; i++)
    begin
      g = $urandom % 2;
      hi = (i < 2) ? 1'b1 : 1'($urandom);
      d = (i < 2) ? 8'hff : 8'($urandom);
      wbyte(g, hi, d);
      exp_w[g] = upd(exp_w[g], hi, d);
      chk(g);
      ev(g, ($urandom % 4) == 0, 1'($urandom));
    end
    // Window write answered by a read in the very next cycle
    d = 8'($urandom);
    npt_sw_model_i.sel(3'h1, 4'h3, 8'h0f);
    npt_sw_model_i.wr_rd(8'ha0, d, q);
    exp_w[0] = upd(exp_w[0], 1'b0, d);
    cmp_b("write then read", d, q);
    chk(0);
    // Wrong space, port outside 3..4, offset outside the word
    bad = '{{3'h2, 4'h3, 8'h0e}, {3'h1, 4'h5, 8'h0e}, {3'h1, 4'h3, 8'h0d}};
    for (int k = 0; k < 3; k++)
    begin
      npt_sw_model_i.sel(bad[k][14:12], bad[k][11:8], bad[k][7:0]);
      npt_sw_model_i.acc(1'b1, 8'ha0, 8'h5a, q);
      npt_sw_model_i.acc(1'b0, 8'ha0, 8'h00, q);
      cmp_b("refused read", 8'h00, q);
      chk(0);
    end
    npt_sw_model_i.acc(1'b1, 8'h55, 8'hff, q);
    npt_sw_model_i.acc(1'b0, 8'h55, 8'h00, q);
    cmp_b("unmapped read", 8'h00, q);
    chk(1);
    // Selection bytes read back as last written by the check above
    npt_sw_model_i.acc(1'b0, 8'h6e, 8'h00, q);
    cmp_b("control readback", 8'h24, q);
    npt_sw_model_i.acc(1'b0, 8'h6f, 8'h00, q);
    cmp_b("offset readback", 8'h0f, q);
    // Manual page use follows the automatic exchange flag
    @(negedge clk_i);
    auto_eee = 2'b01;
    @(negedge clk_i);
    cmp_b("manual flag", 8'h02, {6'h00, manual_np});
    close_out();
  end
  // Watchdog at 20000 cycles, far beyond the few hundred cycles the tests take
  initial
  begin
    #100us;
    error_cnt++;
    close_out();
  end
endmodule
